// >>> design/sdsc_pkg.sv
// Shared constants and types for the serially programmed divider core.
// Assumes a single AXI4-Lite slave with 32-bit data and byte addresses.
package sdsc_pkg;

  // ----------------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------------
  localparam int WORD_W     = 19;
  localparam int CTRL_POS   = 0;
  localparam int REF_LSB    = 1;
  localparam int REF_MSB    = 14;
  localparam int PRESEL_POS = 15;
  localparam int SWAL_LSB   = 1;
  localparam int SWAL_MSB   = 7;
  localparam int MAIN_LSB   = 8;
  localparam int MAIN_MSB   = 18;

  // ----------------------------------------------------------------------
  // Divider settings and reset values
  // ----------------------------------------------------------------------
  localparam logic [13:0] REF_RST   = 14'h0003;
  localparam logic        PRE_RST   = 1'b0;
  localparam logic [6:0]  SWAL_RST  = 7'h00;
  localparam logic [10:0] MAIN_RST  = 11'h003;
  localparam logic [7:0]  MOD_LOW   = 8'h40;
  localparam logic [7:0]  MOD_HIGH  = 8'h80;

  typedef struct packed {
    logic [13:0] ref_div;
    logic        presel;
    logic [6:0]  swallow;
    logic [10:0] main_cnt;
  } sdsc_cfg_t;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_REF   = 8'h04;
  localparam logic [7:0] OFF_FB    = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam int         RUN_POS   = 0;
  localparam int         FB_MAIN_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> design/sdsc_top.sv
// Divider core: serial load link, reference and pulse-swallow dividers,
// phase comparator and AXI4-Lite register access.
// Assumes the host stops the link clock while latch enable is high.
//
// How it works
// - Host sends bits MSB first; link clock rising edge shifts a 19-bit word.
// - Control bit one loads 14-bit reference divide and prescaler select.
// - Control bit zero loads 7-bit swallow and 11-bit main count.
// - Reference divide is unsigned in word bits S1 through S14.
// - Prescaler select zero picks 128/129, one picks 64/65.
// - Swallow count is unsigned in bits S1 through S7, 0 to 127.
// - Main count is unsigned in word bits S8 through S18.
// - Feedback divides by modulus times main plus swallow; reference by R.
// - Polarity select swaps pump-up and pump-down roles.
// - Monitor shows divided reference when polarity high, else feedback.
// - Comparator tracks phase error within minus to plus one cycle.
// - Locked loop gives only minimum-width up and down pulses.
// - While latch enable is high, pump output also drives bypass switch.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module sdsc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        link_clk,
  input  wire logic        serial_data,
  input  wire logic        latch_enable,
  input  wire logic        osc_in,
  input  wire logic        rf_in,
  input  wire logic        phase_polarity_select,
  output logic             charge_pump_out,
  output logic             charge_pump_oe,
  output logic             bypass_switch_out,
  output logic             bypass_switch_oe,
  output logic             divider_monitor_out
);

  // ----------------------------------------------------------------------
  // Link domain shift register
  // ----------------------------------------------------------------------
  logic [18:0] shift_word;

  always_ff @(posedge link_clk) begin
    shift_word <= {shift_word[17:0], serial_data};
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] le_sync;
  logic [1:0] osc_sync;
  logic [1:0] rf_sync;
  logic [1:0] pol_sync;
  logic       le_last;
  logic       osc_last;
  logic       rf_last;

  // Each pin passes two flops before use; only the second stage is read.
  always_ff @(posedge aclk) begin
    le_sync  <= {le_sync[0], latch_enable};
    osc_sync <= {osc_sync[0], osc_in};
    rf_sync  <= {rf_sync[0], rf_in};
    pol_sync <= {pol_sync[0], phase_polarity_select};
  end

  always_ff @(posedge aclk) begin
    le_last  <= le_sync[1];
    osc_last <= osc_sync[1];
    rf_last  <= rf_sync[1];
  end

  logic le_rise;
  logic osc_rise;
  logic rf_rise;
  assign le_rise  = le_sync[1] & ~le_last;
  assign osc_rise = osc_sync[1] & ~osc_last;
  assign rf_rise  = rf_sync[1] & ~rf_last;

  // ----------------------------------------------------------------------
  // Intermediate word latch
  // ----------------------------------------------------------------------
  // The link clock is idle while latch enable is high, so the word is quiet
  // when the synchronised edge arrives. Copying it here first keeps the
  // crossing to one qualified capture, and the divider latches read only
  // flops of this clock.
  logic [18:0] word_hold;
  logic        word_new;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_hold <= 19'h0;
      word_new  <= 1'b0;
    end else begin
      word_new <= le_rise;
      if (le_rise) begin
        word_hold <= shift_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Divider latches
  // ----------------------------------------------------------------------
  sdsc_pkg::sdsc_cfg_t cfg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg.ref_div  <= sdsc_pkg::REF_RST;
      cfg.presel   <= sdsc_pkg::PRE_RST;
      cfg.swallow  <= sdsc_pkg::SWAL_RST;
      cfg.main_cnt <= sdsc_pkg::MAIN_RST;
    end else if (word_new) begin
      if (word_hold[sdsc_pkg::CTRL_POS]) begin
        cfg.ref_div <= word_hold[sdsc_pkg::REF_MSB:sdsc_pkg::REF_LSB];
        cfg.presel  <= word_hold[sdsc_pkg::PRESEL_POS];
      end else begin
        cfg.swallow  <= word_hold[sdsc_pkg::SWAL_MSB:sdsc_pkg::SWAL_LSB];
        cfg.main_cnt <= word_hold[sdsc_pkg::MAIN_MSB:sdsc_pkg::MAIN_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------------
  logic        run;
  logic [13:0] ref_cnt;
  logic        ref_ev;
  logic        ref_level;
  // The host never programs a ratio below three, so the wrap compare never
  // meets a ratio of zero and the level always has a low phase.

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      ref_cnt   <= 14'h0000;
      ref_ev    <= 1'b0;
      ref_level <= 1'b0;
    end else begin
      ref_ev <= 1'b0;
      if (osc_rise) begin
        if (ref_cnt >= cfg.ref_div - 14'h0001) begin
          ref_cnt   <= 14'h0000;
          ref_ev    <= 1'b1;
          ref_level <= 1'b1;
        end else begin
          ref_cnt   <= ref_cnt + 14'h0001;
          ref_level <= (ref_cnt < (cfg.ref_div >> 1)) ? 1'b1 : 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pulse-swallow feedback divider
  // ----------------------------------------------------------------------
  logic [7:0]  pre_cnt;
  logic [6:0]  swal_left;
  logic [10:0] main_left;
  logic        fb_ev;
  logic        fb_level;
  logic [7:0]  modulus;

  always_comb begin
    modulus = cfg.presel ? sdsc_pkg::MOD_LOW : sdsc_pkg::MOD_HIGH;
    if (swal_left != 7'h00) begin
      modulus = modulus + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      pre_cnt   <= 8'h00;
      swal_left <= cfg.swallow;
      main_left <= cfg.main_cnt;
      fb_ev     <= 1'b0;
      fb_level  <= 1'b0;
    end else begin
      fb_ev <= 1'b0;
      if (rf_rise) begin
        if (pre_cnt == modulus - 8'h01) begin
          pre_cnt <= 8'h00;
          if (main_left <= 11'h001) begin
            main_left <= cfg.main_cnt;
            swal_left <= cfg.swallow;
            fb_ev     <= 1'b1;
            fb_level  <= 1'b1;
          end else begin
            main_left <= main_left - 11'h001;
            // The level follows the count left after this cycle, so even a
            // main count of three gives the monitor one low phase.
            fb_level  <= ((main_left - 11'h001) > (cfg.main_cnt >> 1));
            if (swal_left != 7'h00) begin
              swal_left <= swal_left - 7'h01;
            end
          end
        end else begin
          pre_cnt <= pre_cnt + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Phase comparator and pump outputs
  // ----------------------------------------------------------------------
  // A second edge on one side while its flag is set is absorbed, which
  // bounds the detected error to one full cycle either way.
  logic ph_up;
  logic ph_dn;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_up <= 1'b0;
      ph_dn <= 1'b0;
    end else begin
      // A new edge wins over the clear in the same cycle, so none is lost.
      ph_up <= ref_ev | (ph_up & ~ph_dn);
      ph_dn <= fb_ev | (ph_dn & ~ph_up);
    end
  end

  logic pump_src;
  logic pump_snk;
  assign pump_src = pol_sync[1] ? ph_up : ph_dn;
  assign pump_snk = pol_sync[1] ? ph_dn : ph_up;

  // Pump out high sources current, low sinks it, whenever oe is high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_pump_out <= 1'b0;
      charge_pump_oe  <= 1'b0;
    end else begin
      charge_pump_out <= pump_src;
      charge_pump_oe  <= pump_src ^ pump_snk;
    end
  end

  // The switch path only drives while latch enable is high; outside that
  // window the pin is released and the pump pin alone carries the current.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bypass_switch_out <= 1'b0;
      bypass_switch_oe  <= 1'b0;
    end else begin
      bypass_switch_out <= pump_src;
      bypass_switch_oe  <= le_sync[1] & (pump_src ^ pump_snk);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divider_monitor_out <= 1'b0;
    end else begin
      divider_monitor_out <= pol_sync[1] ? ref_level : fb_level;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave: register decode
  // ----------------------------------------------------------------------
  // Write and read answer alike, so one decode keeps their maps in step.
  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == sdsc_pkg::OFF_CTRL) ||
                 (addr == sdsc_pkg::OFF_REF) ||
                 (addr == sdsc_pkg::OFF_FB) ||
                 (addr == sdsc_pkg::OFF_STAT);
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite slave: write channel
  // ----------------------------------------------------------------------
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  // The response waits until both halves are held, in either order.
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sdsc_pkg::RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      run           <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (reg_mapped(aw_addr)) begin
          s_axi_bresp <= sdsc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= sdsc_pkg::RESP_SLVERR;
        end
        // Writes to the read-only words are answered and then ignored.
        if (aw_addr == sdsc_pkg::OFF_CTRL && w_strb[0]) begin
          run <= w_data[sdsc_pkg::RUN_POS];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave: read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sdsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (reg_mapped(s_axi_araddr)) begin
        s_axi_rresp <= sdsc_pkg::RESP_OKAY;
      end else begin
        s_axi_rresp <= sdsc_pkg::RESP_SLVERR;
      end
      case (s_axi_araddr)
        sdsc_pkg::OFF_CTRL: s_axi_rdata <= {31'h0, run};
        sdsc_pkg::OFF_REF:  s_axi_rdata <= {17'h0, cfg.presel, cfg.ref_div};
        sdsc_pkg::OFF_FB:
          s_axi_rdata <= {5'h0, cfg.main_cnt, 9'h0, cfg.swallow};
        sdsc_pkg::OFF_STAT:
          s_axi_rdata <= {28'h0, pol_sync[1], le_sync[1], ph_dn, ph_up};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// >>> tb/sdsc_asserts.sv
// Checker for the divider core's bus handshakes and bypass output.
// Assumes it is bound to sdsc_top and sees only that module's ports.
`timescale 1ns/100ps
module sdsc_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        latch_enable,
  input wire logic        charge_pump_out,
  input wire logic        charge_pump_oe,
  input wire logic        bypass_switch_out,
  input wire logic        bypass_switch_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped early");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while answer pending");
  chk_w_blocked: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write open while busy");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_r_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h0c |=> s_axi_rvalid && s_axi_rdata == 32'h0 &&
    s_axi_rresp == sdsc_pkg::RESP_SLVERR) else $error("bad unmapped read");
  chk_bypass_copy: assert property (bypass_switch_oe |->
    charge_pump_oe && bypass_switch_out == charge_pump_out)
    else $error("bypass differs from pump");
  chk_bypass_idle: assert property (!latch_enable [*4] |=>
    !bypass_switch_oe) else $error("bypass driven with latch low");
endmodule
bind sdsc_top sdsc_asserts u_sdsc_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .latch_enable(latch_enable),
  .charge_pump_out(charge_pump_out), .charge_pump_oe(charge_pump_oe),
  .bypass_switch_out(bypass_switch_out),
  .bypass_switch_oe(bypass_switch_oe));

// >>> tb/sdsc_host.sv
// Host model of the serial link: shifts a word, then pulses latch enable.
// Assumes the bench calls send_word and nothing else drives these pins.
`timescale 1ns/100ps
module sdsc_host (
  output logic link_clk,
  output logic serial_data,
  output logic latch_enable
);
  initial begin
    link_clk = 1'b0;
    serial_data = 1'b0;
    latch_enable = 1'b0;
  end
  // The clock stands low between frames, and the idle data line shows the
  // inverse of its last bit so that a held value cannot be relied on.
  task automatic send_word(input logic [18:0] w, input logic pulse);
    #7;
    for (int i = 18; i >= 0; i--) begin
      serial_data = w[i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    serial_data = ~w[0];
    #40 latch_enable = pulse;
    #160 latch_enable = 1'b0;
    #40;
  endtask
endmodule

// >>> tb/sdsc_top_tb.sv
// Self-checking bench for the divider core: register reads, link loads,
// divider ratios seen at the monitor pin.
// Assumes the host model and checker files are compiled alongside.
`timescale 1ns/100ps
module sdsc_top_tb;
  typedef struct packed {
    logic [18:0] w;
    logic [31:0] r;
    logic [31:0] f;
  } sdsc_row_t;
  logic        aclk = 1'b0, aresetn = 1'b0, pol = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, osc = 1'b0, rf = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, mon;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  gen = 3'h0;
  logic        lclk, sdat, le, cp, cp_oe, bs, bs_oe;
  int          error_cnt = 0, check_count = 0, src_n = 0, snk_n = 0;
  // Range limits of divide values are kept by every row below.
  sdsc_row_t   rows [4] = '{
    '{{3'h5, 1'b0, 14'h3fff, 1'b1}, 32'h3fff, 32'h00030000},
    '{{11'h7ff, 7'h7f, 1'b0}, 32'h3fff, 32'h07ff007f},
    '{{3'h7, 1'b1, 14'h0003, 1'b1}, 32'h4003, 32'h07ff007f},
    '{{11'h003, 7'h02, 1'b0}, 32'h4003, 32'h00030002}};

  // ----------------------------------------------------------------------
  // Design, host and stimulus
  // ----------------------------------------------------------------------
  sdsc_top u_sdsc_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_clk(lclk),
    .serial_data(sdat), .latch_enable(le), .osc_in(osc), .rf_in(rf),
    .phase_polarity_select(pol), .charge_pump_out(cp),
    .charge_pump_oe(cp_oe), .bypass_switch_out(bs),
    .bypass_switch_oe(bs_oe), .divider_monitor_out(mon));
  sdsc_host u_sdsc_host (.link_clk(lclk), .serial_data(sdat),
    .latch_enable(le));
  always #2 aclk = ~aclk;
  // Both pin inputs run at one eighth of aclk, within the sync limit.
  always @(posedge aclk) begin
    gen <= gen + 3'h1;
    osc <= gen[2];
    rf <= gen[2];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rises(input int len, output logic [31:0] n);
    logic prev;
    n = 0;
    src_n = 0;
    snk_n = 0;
    @(posedge aclk);
    prev = mon;
    repeat (len) begin
      @(posedge aclk);
      if (mon === 1'b1 && prev === 1'b0) n++;
      if (cp_oe === 1'b1 && cp === 1'b1) src_n++;
      if (cp_oe === 1'b1 && cp === 1'b0) snk_n++;
      prev = mon;
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(sdsc_pkg::OFF_REF);
    chk(d, 32'h3);
    axi_rd(sdsc_pkg::OFF_FB);
    chk(d, 32'h00030000);
    $display("test reset done");
    foreach (rows[i]) begin
      u_sdsc_host.send_word(rows[i].w, 1'b1);
      repeat (8) @(posedge aclk);
      axi_rd(sdsc_pkg::OFF_REF);
      chk(d, rows[i].r);
      axi_rd(sdsc_pkg::OFF_FB);
      chk(d, rows[i].f);
    end
    $display("test rows done");
    u_sdsc_host.send_word({3'h0, 1'b0, 14'h0100, 1'b1}, 1'b0);
    repeat (8) @(posedge aclk);
    axi_rd(sdsc_pkg::OFF_REF);
    chk(d, 32'h4003);
    axi_rd(8'h10);
    chk(d, 32'h0);
    chk(32'(r), 32'(sdsc_pkg::RESP_SLVERR));
    axi_wr(8'h20, 32'h1);
    chk(32'(r), 32'(sdsc_pkg::RESP_SLVERR));
    axi_wr(sdsc_pkg::OFF_REF, 32'h0);
    chk(32'(r), 32'(sdsc_pkg::RESP_OKAY));
    axi_rd(sdsc_pkg::OFF_REF);
    chk(d, 32'h4003);
    $display("test bus done");
    axi_wr(sdsc_pkg::OFF_CTRL, 32'h1);
    axi_rd(sdsc_pkg::OFF_CTRL);
    chk(d, 32'h1);
    u_sdsc_host.send_word(rows[3].w, 1'b1);
    repeat (200) @(posedge aclk);
    rises(240, d);
    chk(d, 32'd10);
    chk({31'h0, src_n > snk_n}, 32'h1);
    pol <= 1'b0;
    repeat (400) @(posedge aclk);
    rises(3104, d);
    chk(d, 32'd2);
    chk({31'h0, snk_n > src_n}, 32'h1);
    $display("test divider done");
    conclude();
  end
endmodule
